// [verilog/rot_dec_unit.sv]
// Rotate group and index decrement execution datapath.
// Functional notes
// - FD 2B decrements second index, 10 states.
// - DD 2B decrements first index, same timing.
// - Index decrement leaves all flags unchanged.
// - Opcode 07 rotates accumulator left circular.
// - Opcode 17 rotates accumulator left via carry.
// - Opcode 0F rotates accumulator right circular.
// - Opcode 1F rotates accumulator right via carry.
// - Accumulator rotates clear H, N; keep S, Z, PV.
// - Three-bit field selects register B through A.
// - Prefixed rotates set S, Z, parity, carry.
// - CB 06 rotates byte at pointer pair.
// - DD CB d 06 rotates byte at first index.
// - FD CB d 06 rotates byte at second index.
`timescale 1ns/1ps
`include "rot_dec_map.svh"
module rot_dec_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Instruction from the decoder
  input wire logic instr_valid,
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  // Register file view
  input wire logic [7:0] flags_in,
  input wire logic [7:0] reg_in,
  input wire logic [15:0] pointer_pair,
  input wire logic [15:0] first_index_register,
  input wire logic [15:0] second_index_register,
  // Memory bus
  input wire logic [7:0] mem_rdata,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  // Results
  output logic busy,
  output logic illegal,
  output logic [2:0] reg_sel,
  output logic done,
  output logic reg_we,
  output logic [7:0] reg_out,
  output logic flags_we,
  output logic [7:0] flags_out,
  output logic idx_we,
  output logic idx_sel,
  output logic [15:0] idx_out
);
  rot_dec_pkg::state_e state_r, state_nxt;
  rot_dec_pkg::op_e op_r, op_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic isel_r, isel_nxt;
  logic [15:0] iout_r, iout_nxt;
  logic done_r, done_nxt;
  logic rwe_r, rwe_nxt;
  logic fwe_r, fwe_nxt;
  logic iwe_r, iwe_nxt;
  logic rd_r, rd_nxt;
  logic wr_r, wr_nxt;
  logic ill_r, ill_nxt;
  logic cnt_start;
  logic [4:0] cnt_len;
  logic [4:0] cnt_val;
  logic cnt_last;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] rotl8(input logic [7:0] v);
    rotl8 = {v[7], v[6:0], v[7]};
  endfunction

  function automatic logic [7:0] prefixed_flags(input logic [7:0] res, input logic cy,
                                                input logic [7:0] old);
    logic [7:0] f;
    f = old;
    f[`FLAG_S] = res[7];
    f[`FLAG_Z] = (res == 8'h00);
    f[`FLAG_PV] = ~^res;
    f[`FLAG_H] = 1'b0;
    f[`FLAG_N] = 1'b0;
    f[`FLAG_C] = cy;
    prefixed_flags = f;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  state_counter u_cnt (
    .core_clk(core_clk),
    .rst(rst),
    .start(cnt_start),
    .length(cnt_len),
    .count(cnt_val),
    .last(cnt_last)
  );

  always_comb begin
    logic [8:0] rot;
    logic [7:0] f;
    logic [15:0] disp;
    rot = 9'h000;
    f = flags_in;
    disp = {{8{byte2[7]}}, byte2};
    state_nxt = state_r;
    op_nxt = op_r;
    opc_nxt = opc_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    flags_nxt = flags_r;
    sel_nxt = sel_r;
    isel_nxt = isel_r;
    iout_nxt = iout_r;
    done_nxt = 1'b0;
    rwe_nxt = 1'b0;
    fwe_nxt = 1'b0;
    iwe_nxt = 1'b0;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    ill_nxt = 1'b0;
    cnt_start = 1'b0;
    cnt_len = 5'h00;
    case (state_r)
      rot_dec_pkg::ST_IDLE: begin
        if (instr_valid) begin
          op_nxt = rot_dec_pkg::OP_NONE;
          opc_nxt = byte0;
          if ((byte0 == `OP_PFX_FIRST || byte0 == `OP_PFX_SECOND) &&
              byte1 == `OP_DEC_IDX) begin
            op_nxt = rot_dec_pkg::OP_DEC;
            isel_nxt = (byte0 == `OP_PFX_SECOND);
            iout_nxt = isel_nxt ? second_index_register - 16'h0001
                                : first_index_register - 16'h0001;
            cnt_len = `T_DEC_IDX;
          end else if (byte0 == `OP_ACC_ROTL_CIRC || byte0 == `OP_ACC_RL ||
                       byte0 == `OP_ACC_RRC || byte0 == `OP_ACC_RR) begin
            op_nxt = rot_dec_pkg::OP_ACC;
            sel_nxt = `REG_ACC_CODE;
            cnt_len = `T_ACC_ROT;
          end else if (byte0 == `OP_PFX_ROT && byte1 == `OP_ROTL_MEM) begin
            op_nxt = rot_dec_pkg::OP_PTR;
            addr_nxt = pointer_pair;
            cnt_len = `T_ROTL_PTR;
          end else if (byte0 == `OP_PFX_ROT && byte1[7:3] == `ROTL_REG_HI_ZERO) begin
            op_nxt = rot_dec_pkg::OP_REG;
            sel_nxt = byte1[2:0];
            cnt_len = `T_ROTL_REG;
          end else if ((byte0 == `OP_PFX_FIRST || byte0 == `OP_PFX_SECOND) &&
                       byte1 == `OP_PFX_ROT && byte3 == `OP_ROTL_MEM) begin
            op_nxt = rot_dec_pkg::OP_IDX;
            addr_nxt = (byte0 == `OP_PFX_SECOND) ? second_index_register + disp
                                                 : first_index_register + disp;
            cnt_len = `T_ROTL_IDX;
          end
          if (op_nxt == rot_dec_pkg::OP_NONE) begin
            ill_nxt = 1'b1;
          end else begin
            cnt_start = 1'b1;
            state_nxt = rot_dec_pkg::ST_EXEC;
          end
        end
      end
      rot_dec_pkg::ST_EXEC: begin
        if (op_r == rot_dec_pkg::OP_PTR || op_r == rot_dec_pkg::OP_IDX) begin
          if (cnt_val == ((op_r == rot_dec_pkg::OP_PTR) ? `T_PTR_RD : `T_IDX_RD)) begin
            rd_nxt = 1'b1;
            state_nxt = rot_dec_pkg::ST_MEM_RD;
          end
        end else if (cnt_last) begin
          case (op_r)
            rot_dec_pkg::OP_DEC: begin
              iwe_nxt = 1'b1;
            end
            rot_dec_pkg::OP_ACC: begin
              case (opc_r)
                `OP_ACC_ROTL_CIRC: rot = rotl8(reg_in);
                `OP_ACC_RL: rot = {reg_in[7], reg_in[6:0], flags_in[`FLAG_C]};
                `OP_ACC_RRC: rot = {reg_in[0], reg_in[0], reg_in[7:1]};
                default: rot = {reg_in[0], flags_in[`FLAG_C], reg_in[7:1]};
              endcase
              f[`FLAG_H] = 1'b0;
              f[`FLAG_N] = 1'b0;
              f[`FLAG_C] = rot[8];
              data_nxt = rot[7:0];
              flags_nxt = f;
              rwe_nxt = 1'b1;
              fwe_nxt = 1'b1;
            end
            default: begin
              rot = rotl8(reg_in);
              data_nxt = rot[7:0];
              flags_nxt = prefixed_flags(rot[7:0], rot[8], flags_in);
              rwe_nxt = 1'b1;
              fwe_nxt = 1'b1;
            end
          endcase
          done_nxt = 1'b1;
          state_nxt = rot_dec_pkg::ST_DONE;
        end
      end
      rot_dec_pkg::ST_MEM_RD: begin
        rot = rotl8(mem_rdata);
        data_nxt = rot[7:0];
        flags_nxt = prefixed_flags(rot[7:0], rot[8], flags_in);
        state_nxt = rot_dec_pkg::ST_MEM_WR;
      end
      rot_dec_pkg::ST_MEM_WR: begin
        if (cnt_val == ((op_r == rot_dec_pkg::OP_PTR) ? `T_PTR_WR : `T_IDX_WR)) begin
          wr_nxt = 1'b1;
        end
        if (cnt_last) begin
          fwe_nxt = 1'b1;
          done_nxt = 1'b1;
          state_nxt = rot_dec_pkg::ST_DONE;
        end
      end
      rot_dec_pkg::ST_DONE: begin
        state_nxt = rot_dec_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = rot_dec_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= rot_dec_pkg::ST_IDLE;
      op_r <= rot_dec_pkg::OP_NONE;
      opc_r <= 8'h00;
      addr_r <= 16'h0000;
      data_r <= 8'h00;
      flags_r <= 8'h00;
      sel_r <= 3'h0;
      isel_r <= 1'b0;
      iout_r <= 16'h0000;
      done_r <= 1'b0;
      rwe_r <= 1'b0;
      fwe_r <= 1'b0;
      iwe_r <= 1'b0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      ill_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      opc_r <= opc_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      flags_r <= flags_nxt;
      sel_r <= sel_nxt;
      isel_r <= isel_nxt;
      iout_r <= iout_nxt;
      done_r <= done_nxt;
      rwe_r <= rwe_nxt;
      fwe_r <= fwe_nxt;
      iwe_r <= iwe_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      ill_r <= ill_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy = (state_r != rot_dec_pkg::ST_IDLE);
  assign illegal = ill_r;
  assign reg_sel = sel_r;
  assign done = done_r;
  assign reg_we = rwe_r;
  assign reg_out = data_r;
  assign flags_we = fwe_r;
  assign flags_out = flags_r;
  assign idx_we = iwe_r;
  assign idx_sel = isel_r;
  assign idx_out = iout_r;
  assign mem_rd = rd_r;
  assign mem_wr = wr_r;
  assign mem_addr = addr_r;
  assign mem_wdata = data_r;
endmodule

// [verilog/rot_dec_map.svh]
// Opcodes, flag positions, state timing and bus constants for the rotate/decrement datapath.
`ifndef ROT_DEC_MAP_SVH
`define ROT_DEC_MAP_SVH
`define OP_PFX_FIRST 8'hDD
`define OP_PFX_SECOND 8'hFD
`define OP_PFX_ROT 8'hCB
`define OP_DEC_IDX 8'h2B
`define OP_ACC_ROTL_CIRC 8'h07
`define OP_ACC_RL 8'h17
`define OP_ACC_RRC 8'h0F
`define OP_ACC_RR 8'h1F
`define OP_ROTL_MEM 8'h06
`define ROTL_REG_HI_ZERO 5'h00
`define REG_MEM_CODE 3'h6
`define REG_ACC_CODE 3'h7
`define FLAG_S 7
`define FLAG_Z 6
`define FLAG_H 4
`define FLAG_PV 2
`define FLAG_N 1
`define FLAG_C 0
`define T_DEC_IDX 5'h0A
`define T_ACC_ROT 5'h04
`define T_ROTL_REG 5'h08
`define T_ROTL_PTR 5'h0F
`define T_ROTL_IDX 5'h17
`define T_PTR_RD 5'h08
`define T_PTR_WR 5'h0C
`define T_IDX_RD 5'h0F
`define T_IDX_WR 5'h14
`endif

// [verilog/rot_dec_pkg.sv]
// Types shared by the rotate/decrement datapath.
package rot_dec_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_MEM_RD = 3'b010,
    ST_MEM_WR = 3'b011,
    ST_DONE = 3'b100
  } state_e;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_DEC = 3'b001,
    OP_ACC = 3'b010,
    OP_REG = 3'b011,
    OP_PTR = 3'b100,
    OP_IDX = 3'b101
  } op_e;
endpackage

// [verilog/state_counter.sv]
// Clock-state counter that measures out the length of one instruction.
`timescale 1ns/1ps
module state_counter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [4:0] length,
  // Status
  output logic [4:0] count,
  output logic last
);
  logic [4:0] count_r;
  logic [4:0] count_nxt;
  logic [4:0] len_r;
  logic [4:0] len_nxt;
  logic run_r;
  logic run_nxt;

  always_comb begin
    count_nxt = count_r;
    len_nxt = len_r;
    run_nxt = run_r;
    if (start) begin
      count_nxt = 5'h01;
      len_nxt = length;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (count_r == len_r) begin
        run_nxt = 1'b0;
        count_nxt = 5'h00;
      end else begin
        count_nxt = count_r + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_r <= 5'h00;
      len_r <= 5'h00;
      run_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      len_r <= len_nxt;
      run_r <= run_nxt;
    end
  end

  assign count = count_r;
  assign last = run_r && (count_r == len_r);
endmodule

// [dv/rot_dec_checker.sv]
// Port assertions for the rotate and index decrement datapath.
`timescale 1ns/1ps
`include "rot_dec_map.svh"
module rot_dec_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Observed outputs
  input wire logic busy,
  input wire logic done,
  input wire logic reg_we,
  input wire logic [2:0] reg_sel,
  input wire logic flags_we,
  input wire logic [7:0] flags_out,
  input wire logic idx_we,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  done_pulse_a: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  done_busy_a: assert property (done |-> busy)
    else $error("done seen while idle");
  dec_quiet_a: assert property (idx_we |-> done && !flags_we && !reg_we)
    else $error("decrement touched flags or register");
  rot_clear_a: assert property (flags_we |-> !flags_out[`FLAG_H] && !flags_out[`FLAG_N])
    else $error("half carry or subtract not cleared");
  mem_flags_a: assert property (flags_we && !reg_we |-> flags_out[`FLAG_S] == mem_wdata[7]
    && flags_out[`FLAG_Z] == (mem_wdata == 8'h00) && flags_out[`FLAG_PV] == ~^mem_wdata)
    else $error("memory rotate flags wrong");
  mem_carry_a: assert property (flags_we && !reg_we |-> flags_out[`FLAG_C] == mem_wdata[0])
    else $error("memory rotate carry wrong");
  rd_wr_gap_a: assert property (mem_rd |-> ##[4:5] mem_wr)
    else $error("write back not in time after read");
  addr_hold_a: assert property (mem_rd |=> $stable(mem_addr) [*3])
    else $error("address moved during rotate");
  wr_done_a: assert property (mem_wr |-> ##3 (done && flags_we && !reg_we))
    else $error("memory rotate end misplaced");
  reg_code_a: assert property (reg_we |-> reg_sel != `REG_MEM_CODE && flags_we)
    else $error("register write with memory code");
  dec_cov: cover property (idx_we);
  mem_cov: cover property (mem_wr);
  reg_cov: cover property (reg_we && flags_we);
endmodule

bind rot_dec_unit rot_dec_checker u_chk (.core_clk(core_clk), .rst(rst), .busy(busy),
  .done(done), .reg_we(reg_we), .reg_sel(reg_sel), .flags_we(flags_we),
  .flags_out(flags_out), .idx_we(idx_we), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata));

// [dv/rotate_group_and_index_decrement_tb.sv]
// Self-checking bench for the rotate and index decrement datapath.
`timescale 1ns/1ps
`include "rot_dec_map.svh"
module rotate_group_and_index_decrement_tb;
  logic core_clk = 0, rst = 1, instr_valid = 0;
  logic [7:0] byte0 = 0, byte1 = 0, byte2 = 0, byte3 = 0, flags_in = 0, reg_in = 0;
  logic [7:0] mem_rdata = 0, mval = 0, wd, mem_wdata, reg_out, flags_out;
  logic [15:0] pointer_pair = 0, first_index_register = 0, second_index_register = 0;
  logic [15:0] ra, wa, mem_addr, idx_out, e;
  logic mem_rd, mem_wr, busy, illegal, done, reg_we, flags_we, idx_we, idx_sel;
  logic [2:0] reg_sel;
  int err_count = 0, compares = 0;
  rot_dec_unit dut (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .byte0(byte0), .byte1(byte1), .byte2(byte2), .byte3(byte3), .flags_in(flags_in),
    .reg_in(reg_in), .pointer_pair(pointer_pair), .first_index_register(first_index_register),
    .second_index_register(second_index_register), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy),
    .illegal(illegal), .reg_sel(reg_sel), .done(done), .reg_we(reg_we), .reg_out(reg_out),
    .flags_we(flags_we), .flags_out(flags_out), .idx_we(idx_we), .idx_sel(idx_sel),
    .idx_out(idx_out));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task complete_run;
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    compares++;
    if (got !== ex) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Result byte above the flags expected from a circular left rotate.
  function logic [15:0] rotl_exp(input logic [7:0] v);
    logic [7:0] r;
    r = {v[6:0], v[7]};
    return {r, r[7], r == 8'h00, 3'h0, ~^r, 1'b0, v[7]};
  endfunction
  // Issues one instruction, serves memory and measures states up to done.
  task run(input logic [7:0] a, b, c, d, input int n);
    int k;
    k = 0;
    ra = 'x;
    wa = 'x;
    wd = 'x;
    @(negedge core_clk);
    {byte0, byte1, byte2, byte3} = {a, b, c, d};
    instr_valid = 1;
    @(negedge core_clk);
    instr_valid = 0;
    do begin
      @(negedge core_clk);
      k++;
      mem_rdata = mem_rd ? mval : ~mval;
      if (mem_rd) ra = mem_addr;
      if (mem_wr) {wa, wd} = {mem_addr, mem_wdata};
    end while (done !== 1'b1 && k < 40);
    if (k >= 40) begin
      err_count++;
      complete_run;
    end
    chk("states", 16'(n), 16'(k));
  endtask
  task mem_op(input logic [7:0] a, b, c, input int n, input logic [15:0] ad,
              input logic [7:0] v);
    mval = v;
    e = rotl_exp(v);
    run(a, b, c, `OP_ROTL_MEM, n);
    chk("rd_addr", ad, ra);
    chk("wr_addr", ad, wa);
    chk("wdata", e[15:8], wd);
    chk("mem_flags", e[7:0], flags_out);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task dec_test;
    first_index_register = 16'h2006;
    second_index_register = 16'h0000;
    flags_in = 8'hFF;
    run(`OP_PFX_FIRST, `OP_DEC_IDX, 8'h00, 8'h00, 10);
    chk("first_idx", 16'h2005, idx_out);
    chk("dec_ctl", 16'h0004, {idx_we, idx_sel, flags_we});
    run(`OP_PFX_SECOND, `OP_DEC_IDX, 8'h00, 8'h00, 10);
    chk("second_idx", 16'hFFFF, idx_out);
    chk("dec_wrap_ctl", 16'h0006, {idx_we, idx_sel, flags_we});
  endtask
  task automatic acc_test;
    logic [7:0] op[4] = '{8'h07, 8'h17, 8'h0F, 8'h1F};
    logic [7:0] av[4] = '{8'h88, 8'h76, 8'h11, 8'hE1};
    logic [7:0] rv[4] = '{8'h11, 8'hED, 8'h88, 8'h70};
    logic ci[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic co[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      reg_in = av[i];
      flags_in = 8'hD6 | {7'h00, ci[i]};
      run(op[i], 8'h00, 8'h00, 8'h00, 4);
      chk("acc", rv[i], reg_out);
      chk("acc_flags", 8'hC4 | {7'h00, co[i]}, flags_out);
      chk("acc_ctl", 16'h001F, {reg_we, flags_we, reg_sel});
    end
  endtask
  task reg_test;
    flags_in = 8'h12;
    for (int c = 0; c < 8; c++) begin
      if (c == 6) continue;
      reg_in = {3'(c), 5'h00};
      e = rotl_exp(reg_in);
      run(`OP_PFX_ROT, {5'h00, 3'(c)}, 8'h00, 8'h00, 8);
      chk("reg", e[15:8], reg_out);
      chk("reg_flags", e[7:0], flags_out);
      chk("reg_sel", 16'(c), reg_sel);
    end
  endtask
  task mem_test;
    pointer_pair = 16'h2828;
    first_index_register = 16'h1000;
    second_index_register = 16'h1000;
    mem_op(`OP_PFX_ROT, `OP_ROTL_MEM, 8'h00, 15, 16'h2828, 8'h88);
    mem_op(`OP_PFX_FIRST, `OP_PFX_ROT, 8'h02, 23, 16'h1002, 8'h00);
    mem_op(`OP_PFX_SECOND, `OP_PFX_ROT, 8'hFE, 23, 16'h0FFE, 8'hC3);
  endtask
  task bad_test;
    @(negedge core_clk);
    {byte0, byte1} = {`OP_PFX_ROT, 8'h08};
    instr_valid = 1;
    @(negedge core_clk);
    instr_valid = 0;
    chk("illegal", 16'h0002, {illegal, busy});
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst = 0;
    dec_test;
    acc_test;
    reg_test;
    mem_test;
    bad_test;
    complete_run;
  end
endmodule
